// ==== src/vcc_pkg.sv ====
// Shared constants for the voice codec control block.
package vcc_pkg;
    // ------------------------------------------------------------------
    // Register byte addresses on the AHB-Lite slave.
    // ------------------------------------------------------------------
    localparam logic [7:0] FORMAT_OFS = 8'h00; // Law, frame format and timing.
    localparam logic [7:0] CHAN_OFS = 8'h04; // Slot, voice enable, latch.
    localparam logic [7:0] TXBYTE_OFS = 8'h08; // Byte sent in the selected slot.
    localparam logic [7:0] RXBYTE_OFS = 8'h0c; // Last received voice byte.
    localparam logic [7:0] PATH_OFS = 8'h10; // Path select.
    localparam logic [7:0] TXGAIN_OFS = 8'h14; // Transmit gain and sidetone.
    localparam logic [7:0] RXATT_OFS = 8'h18; // Receive attenuations.
    localparam logic [7:0] TONE_OFS = 8'h1c; // Tone level.
    localparam logic [7:0] RING1_OFS = 8'h20; // First ring frequency.
    localparam logic [7:0] RING2_OFS = 8'h24; // Second ring frequency.
    localparam logic [7:0] DAS_OFS = 8'h28; // Anticlipping and loudspeaker gain.
    localparam logic [7:0] POWER_OFS = 8'h2c; // One-byte power instruction.
    localparam logic [7:0] STATUS_OFS = 8'h30; // Read-only state.
    // ------------------------------------------------------------------
    // Field positions.
    // ------------------------------------------------------------------
    localparam int PWR_BIT = 8; // Power bit carried by every config write.
    localparam int ONE_PWR_BIT = 0; // Power bit of the one-byte instruction.
    localparam int ONE_ZERO_BIT = 1; // Must be zero in the one-byte instruction.
    localparam int FMT_FIRST = 0; // law_select_first.
    localparam int FMT_SECOND = 1; // law_select_second.
    localparam int FMT_FORMAT2 = 2; // Two-bit gap before the second slot.
    localparam int FMT_DELAYED = 3; // Delayed frame timing.
    localparam int CH_SLOT2 = 0; // Second time slot selected.
    localparam int CH_VOICE_EN = 2; // Voice transfer enabled.
    localparam int CH_LATCH = 3; // Latch output pulled low when set.
    localparam int PS_SECONDARY_MIC_INPUT = 7; // Secondary microphone selected.
    localparam int PS_UNMUTE = 6; // tx_unmute.
    localparam int PS_HFLOOP = 5; // handsfree_loop_en.
    localparam int PS_TONE_EAR = 3; // Tone summed into the earpiece.
    localparam int PS_TONE_SPK = 2; // Tone summed into the loudspeaker.
    localparam int PS_SPK = 1; // speaker_route.
    localparam int PS_EAR = 0; // earpiece_route.
    localparam int DAS_LSHIGH = 4; // Loudspeaker +27dB gain.
    localparam int DAS_AFB = 5; // Anti-feedback switched on.
    // ------------------------------------------------------------------
    // Reset values and slot geometry.
    // ------------------------------------------------------------------
    localparam logic [8:0] REG_RESET = 9'h000;
    localparam logic [7:0] SLOT1_START = 8'h00;
    localparam logic [7:0] SLOT2_START_F1 = 8'h08;
    localparam logic [7:0] SLOT2_START_F2 = 8'h0a;
    localparam logic [7:0] SLOT_LAST_OFS = 8'h07;
    localparam logic [7:0] POS_BEFORE = 8'hff; // One bit before the frame.
    localparam logic [7:0] POS_PARK = 8'hfe; // Counter parks here between frames.
    localparam logic [1:0] ARM_FRAMES = 2'h2; // Frame syncs before output drives.
    localparam logic [7:0] ALAW_XOR = 8'h55;
    localparam logic [3:0] AFB_RANGE_DB = 4'hc; // Anti-feedback control depth.
    localparam logic [3:0] DAS_MAX_STEPS = 4'hf;
    localparam logic [6:0] THR_15 = 7'h58; // -15 dBm0 level code.
    localparam logic [6:0] THR_13 = 7'h5c; // -13 dBm0 level code.
    localparam logic [6:0] THR_9 = 7'h64; // -9 dBm0 level code.
    localparam logic [6:0] THR_7 = 7'h68; // -7 dBm0 level code.
    // ------------------------------------------------------------------
    // Timing.
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 25;
    localparam int CLK_LOSS_NS = 10000; // Silence on the master clock that counts as loss.
    localparam logic [8:0] CLK_LOSS_CYC = 9'(CLK_LOSS_NS / CLK_PERIOD_NS);
    localparam int FRAME_HZ = 8000; // Attack steps once per frame.
    localparam logic [11:0] REL_4HZ = 12'(FRAME_HZ / 4);
    localparam logic [11:0] REL_8HZ = 12'(FRAME_HZ / 8);
    localparam logic [11:0] REL_31HZ = 12'(FRAME_HZ / 31);
    localparam logic [11:0] REL_62HZ = 12'(FRAME_HZ / 62);
endpackage

// ==== src/vcc_top.sv ====
// Voice codec control: registers, PCM slot logic, power and anticlipping.
//
// Behaviour
// - Power bit: zero up, one down.
// - Power with last write or alone.
// - After power up, transmit waits two syncs.
// - Power down keeps registers, still writable.
// - Lost master clock forces reset power down.
// - Path bit7 picks microphone pair.
// - Transmit gain bits7:4, 0-15 dB.
// - Muted transmit grounds signal, kills sidetone.
// - One law setting for encoder, decoder.
// - Shift byte out on slot rising edges.
// - Capture received byte on eight edges.
// - Path bits1,0 route speaker and earpiece.
// - Earpiece attenuation bits7:4, 1 dB steps.
// - Speaker attenuation bits3:0, 2 dB steps.
// - Sidetone and tone levels into outputs.
// - Handsfree loop diverts receive signal.
// - Loudspeaker gain +9dB or +27dB.
// - Anti-feedback gives 12dB control range.
// - Anticlipping at +27dB compares level, cuts speaker gain.
// - Four selectable anticlipping thresholds.
// - Attack per frame; four release rates.
// - Alternate-tone pin picks ring frequency.
//
// Our own choices: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module vcc_top (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic mclk,
    input wire logic fsync,
    input wire logic rx_serial,
    output logic tx_serial_o,
    output logic tx_serial_oe,
    output logic latch_output_o,
    output logic latch_output_oe,
    input wire logic alt_tone_pin,
    input wire logic alt_tone_open,
    output logic powered_up,
    output logic mic_select,
    output logic [3:0] tx_stage2_gain,
    output logic tx_unmute,
    output logic law_mu,
    output logic speaker_route,
    output logic earpiece_route,
    output logic [3:0] earpiece_atten,
    output logic [3:0] speaker_atten,
    output logic [3:0] sidetone_level,
    output logic [3:0] tone_level,
    output logic tone_to_earpiece,
    output logic tone_to_speaker,
    output logic handsfree_loop_en,
    output logic ls_gain_high,
    output logic [3:0] afb_range_db,
    output logic [3:0] das_reduction,
    output logic [7:0] ring_freq,
    output logic ring_auto
);
    import vcc_pkg::*;

    // ------------------------------------------------------------------
    // Register file.
    // ------------------------------------------------------------------
    logic [8:0] format_reg_r; // Law, format, timing.
    logic [8:0] chan_reg_r; // Slot, voice enable, latch.
    logic [7:0] tx_byte_r; // Byte for the transmit slot.
    logic [7:0] rx_byte_r; // Last received byte.
    logic [8:0] path_select_reg_r;
    logic [8:0] tx_gain_reg_r;
    logic [8:0] rx_atten_reg_r;
    logic [8:0] tone_level_reg_r;
    logic [8:0] ring_freq_one_reg_r;
    logic [8:0] ring_freq_two_reg_r;
    logic [8:0] das_reg_r; // Threshold, release, gain, anti-feedback.
    logic powered_r; // Codec powered up.

    // Address phase capture; the write is applied in the data phase.
    logic wr_pend_r;
    logic [7:0] wr_addr_r;
    logic [7:0] rd_addr_r;
    logic rd_pend_r;
    wire addr_phase = hsel & hready & htrans[1];
    wire cfg_write = wr_pend_r && (wr_addr_r <= DAS_OFS) && (wr_addr_r != RXBYTE_OFS);
    wire one_byte_ok = wr_pend_r && (wr_addr_r == POWER_OFS) && !hwdata[ONE_ZERO_BIT];

    // ------------------------------------------------------------------
    // Pin synchronisers and master clock edges.
    // ------------------------------------------------------------------
    logic [1:0] mclk_sy_r;
    logic [1:0] fs_sy_r;
    logic [1:0] dr_sy_r;
    logic [1:0] at_sy_r;
    logic [1:0] ao_sy_r;
    logic mclk_last_r; // Previous synchronised clock level.
    wire mclk_rise = mclk_sy_r[1] & ~mclk_last_r;
    wire mclk_fall = ~mclk_sy_r[1] & mclk_last_r;

    // All four pins and the clock share one delay, so slot timing stays aligned.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            mclk_sy_r <= 2'h0;
            fs_sy_r <= 2'h0;
            dr_sy_r <= 2'h0;
            at_sy_r <= 2'h0;
            ao_sy_r <= 2'h0;
            mclk_last_r <= 1'b0;
        end else begin
            mclk_sy_r <= {mclk_sy_r[0], mclk};
            fs_sy_r <= {fs_sy_r[0], fsync};
            dr_sy_r <= {dr_sy_r[0], rx_serial};
            at_sy_r <= {at_sy_r[0], alt_tone_pin};
            ao_sy_r <= {ao_sy_r[0], alt_tone_open};
            mclk_last_r <= mclk_sy_r[1];
        end
    end

    // ------------------------------------------------------------------
    // Master clock loss watchdog.
    // ------------------------------------------------------------------
    logic [8:0] idle_cnt_r; // Cycles since the last clock edge.
    logic clk_lost_r; // Reset power down in force.
    wire mclk_edge = mclk_rise | mclk_fall;

    // The watchdog cannot tell a slow clock from a lost one below 50 kHz.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            idle_cnt_r <= 9'h000;
            clk_lost_r <= 1'b0;
        end else if (mclk_edge) begin
            idle_cnt_r <= 9'h000;
            clk_lost_r <= 1'b0;
        end else if (idle_cnt_r >= CLK_LOSS_CYC - 9'h001) begin
            clk_lost_r <= 1'b1;
        end else begin
            idle_cnt_r <= idle_cnt_r + 9'h001;
        end
    end

    // ------------------------------------------------------------------
    // Registers and power state.
    // ------------------------------------------------------------------
    // Writes land only in the data phase, once the whole word is present.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            wr_pend_r <= 1'b0;
            rd_pend_r <= 1'b0;
            wr_addr_r <= 8'h00;
            rd_addr_r <= 8'h00;
        end else if (hready) begin
            wr_pend_r <= addr_phase & hwrite;
            rd_pend_r <= addr_phase & ~hwrite;
            wr_addr_r <= haddr[7:0];
            rd_addr_r <= haddr[7:0];
        end
    end

    // Each register keeps its value across power down and stays writable.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            format_reg_r <= REG_RESET;
            chan_reg_r <= REG_RESET;
            tx_byte_r <= 8'h00;
            path_select_reg_r <= REG_RESET;
            tx_gain_reg_r <= REG_RESET;
            rx_atten_reg_r <= REG_RESET;
            tone_level_reg_r <= REG_RESET;
            ring_freq_one_reg_r <= REG_RESET;
            ring_freq_two_reg_r <= REG_RESET;
            das_reg_r <= REG_RESET;
        end else if (wr_pend_r) begin
            case (wr_addr_r)
                FORMAT_OFS: format_reg_r <= hwdata[8:0];
                CHAN_OFS: chan_reg_r <= hwdata[8:0];
                TXBYTE_OFS: tx_byte_r <= hwdata[7:0];
                PATH_OFS: path_select_reg_r <= hwdata[8:0];
                TXGAIN_OFS: tx_gain_reg_r <= hwdata[8:0];
                RXATT_OFS: rx_atten_reg_r <= hwdata[8:0];
                TONE_OFS: tone_level_reg_r <= hwdata[8:0];
                RING1_OFS: ring_freq_one_reg_r <= hwdata[8:0];
                RING2_OFS: ring_freq_two_reg_r <= hwdata[8:0];
                DAS_OFS: das_reg_r <= hwdata[8:0];
                default: begin
                end
            endcase
        end
    end

    // Power follows the bit in any config write or any power byte with its zero bit clear; a lost clock overrides.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            powered_r <= 1'b0;
        end else if (clk_lost_r) begin
            powered_r <= 1'b0;
        end else if (cfg_write) begin
            powered_r <= ~hwdata[PWR_BIT];
        end else if (one_byte_ok) begin
            powered_r <= ~hwdata[ONE_PWR_BIT];
        end
    end

    // ------------------------------------------------------------------
    // PCM frame and time slot logic.
    // ------------------------------------------------------------------
    logic fs_last_r; // Frame sync level at the previous clock rise.
    logic [7:0] pos_r; // Bit position within the frame.
    logic [1:0] arm_cnt_r; // Frame syncs seen since power up.
    logic [7:0] tx_shift_r; // Byte being sent.
    logic [6:0] rx_shift_r; // Bits gathered so far.
    logic rx_done_r; // One-cycle pulse: a whole byte was captured.
    logic dx_r; // Transmit bit.
    logic dx_en_r; // Transmit output driven.
    wire new_frame = mclk_rise & fs_sy_r[1] & ~fs_last_r;
    wire [7:0] slot_start = !chan_reg_r[CH_SLOT2] ? SLOT1_START :
        (format_reg_r[FMT_FORMAT2] ? SLOT2_START_F2 : SLOT2_START_F1);
    wire [7:0] bit_idx = pos_r - slot_start;
    wire in_slot = (pos_r >= slot_start) && (bit_idx <= SLOT_LAST_OFS);
    wire [7:0] pos_nxt = (pos_r == POS_PARK) ? POS_PARK : pos_r + 8'h01;
    wire voice_on = powered_r & chan_reg_r[CH_VOICE_EN];
    wire armed = (arm_cnt_r == ARM_FRAMES);

    // Count frame syncs after power up; the transmit pin stays idle until two.
    always_ff @(posedge sys_clk) begin
        if (rst || !powered_r) begin
            arm_cnt_r <= 2'h0;
        end else if (new_frame && !armed) begin
            arm_cnt_r <= arm_cnt_r + 2'h1;
        end
    end

    // Delayed timing starts the frame one clock after the sync edge.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            fs_last_r <= 1'b0;
            pos_r <= POS_PARK;
            tx_shift_r <= 8'h00;
        end else if (mclk_rise) begin
            fs_last_r <= fs_sy_r[1];
            if (new_frame) begin
                pos_r <= format_reg_r[FMT_DELAYED] ? POS_BEFORE : 8'h00;
                tx_shift_r <= tx_byte_r;
            end else begin
                pos_r <= pos_nxt;
            end
        end
    end

    // Send the byte MSB first on rising edges inside the slot.
    always_ff @(posedge sys_clk) begin
        if (rst || clk_lost_r) begin
            dx_r <= 1'b0;
            dx_en_r <= 1'b0;
        end else if (mclk_rise) begin
            dx_en_r <= in_slot & voice_on & armed;
            dx_r <= tx_shift_r[3'(SLOT_LAST_OFS - bit_idx)];
        end
    end

    // Capture on falling edges; the last bit delivers the whole byte.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rx_shift_r <= 7'h00;
            rx_byte_r <= 8'h00;
            rx_done_r <= 1'b0;
        end else begin
            rx_done_r <= 1'b0;
            if (mclk_fall && in_slot && voice_on) begin
                rx_shift_r <= {rx_shift_r[5:0], dr_sy_r[1]};
                if (bit_idx == SLOT_LAST_OFS) begin
                    rx_byte_r <= {rx_shift_r, dr_sy_r[1]};
                    rx_done_r <= 1'b1;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Anticlipping controller.
    // ------------------------------------------------------------------
    // Map a companded byte to a rising 7-bit level code for either law.
    function automatic logic [6:0] level_of(input logic [7:0] b, input logic mu);
        logic [7:0] x;
        x = mu ? ~b : (b ^ ALAW_XOR);
        return x[6:0];
    endfunction

    logic [11:0] rel_cnt_r; // Frames since the last release step or over-threshold frame.
    logic [3:0] red_r; // Gain reduction steps in force.
    wire [6:0] rx_level = level_of(rx_byte_r, format_reg_r[FMT_FIRST]);
    wire [6:0] thr = (das_reg_r[1:0] == 2'h0) ? THR_15 : (das_reg_r[1:0] == 2'h1) ? THR_13 :
        (das_reg_r[1:0] == 2'h2) ? THR_9 : THR_7;
    wire [11:0] rel_period = (das_reg_r[3:2] == 2'h0) ? REL_4HZ :
        (das_reg_r[3:2] == 2'h1) ? REL_8HZ : (das_reg_r[3:2] == 2'h2) ? REL_31HZ : REL_62HZ;
    wire over = rx_level > thr;

    // One attack step per received frame; release waits out its period.
    always_ff @(posedge sys_clk) begin
        if (rst || !das_reg_r[DAS_LSHIGH]) begin
            red_r <= 4'h0;
            rel_cnt_r <= 12'h000;
        end else if (rx_done_r) begin
            if (over) begin
                rel_cnt_r <= 12'h000;
                if (red_r != DAS_MAX_STEPS) begin
                    red_r <= red_r + 4'h1;
                end
            end else if (rel_cnt_r >= rel_period - 12'h001) begin
                rel_cnt_r <= 12'h000;
                if (red_r != 4'h0) begin
                    red_r <= red_r - 4'h1;
                end
            end else begin
                rel_cnt_r <= rel_cnt_r + 12'h001;
            end
        end
    end

    // ------------------------------------------------------------------
    // Analog control outputs; sidetone and ring selection registered, the rest decoded from registers.
    // ------------------------------------------------------------------
    logic [3:0] sidetone_r;
    logic [7:0] ring_r;
    logic ring_auto_r;
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            sidetone_r <= 4'h0;
            ring_r <= 8'h00;
            ring_auto_r <= 1'b0;
        end else begin
            // Muting the transmitter also silences the sidetone path.
            sidetone_r <= path_select_reg_r[PS_UNMUTE] ? tx_gain_reg_r[3:0] : 4'h0;
            ring_auto_r <= ~ao_sy_r[1];
            if (ao_sy_r[1]) begin
                ring_r <= ring_freq_one_reg_r[7:0];
            end else begin
                ring_r <= at_sy_r[1] ? ring_freq_one_reg_r[7:0] : ring_freq_two_reg_r[7:0];
            end
        end
    end

    assign mic_select = path_select_reg_r[PS_SECONDARY_MIC_INPUT];
    assign tx_stage2_gain = tx_gain_reg_r[7:4];
    assign tx_unmute = path_select_reg_r[PS_UNMUTE];
    assign law_mu = format_reg_r[FMT_FIRST];
    assign speaker_route = path_select_reg_r[PS_SPK];
    assign earpiece_route = path_select_reg_r[PS_EAR];
    assign earpiece_atten = rx_atten_reg_r[7:4];
    assign speaker_atten = rx_atten_reg_r[3:0];
    assign sidetone_level = sidetone_r;
    assign tone_level = tone_level_reg_r[7:4];
    assign tone_to_earpiece = path_select_reg_r[PS_TONE_EAR];
    assign tone_to_speaker = path_select_reg_r[PS_TONE_SPK];
    assign handsfree_loop_en = path_select_reg_r[PS_HFLOOP];
    assign ls_gain_high = das_reg_r[DAS_LSHIGH];
    assign afb_range_db = das_reg_r[DAS_AFB] ? AFB_RANGE_DB : 4'h0;
    assign das_reduction = red_r;
    assign ring_freq = ring_r;
    assign ring_auto = ring_auto_r;
    assign powered_up = powered_r;

    // Open-drain latch drives low only while the clock is present.
    assign latch_output_o = 1'b0;
    assign latch_output_oe = chan_reg_r[CH_LATCH] & ~clk_lost_r;
    assign tx_serial_o = dx_r;
    assign tx_serial_oe = dx_en_r;

    // ------------------------------------------------------------------
    // Bus read data and response.
    // ------------------------------------------------------------------
    wire [31:0] status_word = {20'h00000, ring_auto_r, red_r, at_sy_r[1], armed, clk_lost_r,
        powered_r, 3'h0};
    logic [31:0] rd_mux;
    always_comb begin
        case (rd_addr_r)
            FORMAT_OFS: rd_mux = {23'h000000, format_reg_r};
            CHAN_OFS: rd_mux = {23'h000000, chan_reg_r};
            TXBYTE_OFS: rd_mux = {24'h000000, tx_byte_r};
            RXBYTE_OFS: rd_mux = {24'h000000, rx_byte_r};
            PATH_OFS: rd_mux = {23'h000000, path_select_reg_r};
            TXGAIN_OFS: rd_mux = {23'h000000, tx_gain_reg_r};
            RXATT_OFS: rd_mux = {23'h000000, rx_atten_reg_r};
            TONE_OFS: rd_mux = {23'h000000, tone_level_reg_r};
            RING1_OFS: rd_mux = {23'h000000, ring_freq_one_reg_r};
            RING2_OFS: rd_mux = {23'h000000, ring_freq_two_reg_r};
            DAS_OFS: rd_mux = {23'h000000, das_reg_r};
            STATUS_OFS: rd_mux = status_word;
            default: rd_mux = 32'h00000000;
        endcase
    end

    // Zero-wait slave: every transfer finishes in its first data cycle.
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = rd_pend_r ? rd_mux : 32'h00000000;
endmodule
`default_nettype wire

// ==== verification/vcc_properties.sv ====
// Concurrent checks on the ports of the voice codec control block.
`timescale 1ns/10ps
`default_nettype none
module vcc_properties
    import vcc_pkg::*;
(
    input wire logic sys_clk, rst, hsel, hwrite, hready, mclk,
    input wire logic [31:0] haddr, hwdata,
    input wire logic [1:0] htrans,
    input wire logic powered_up, mic_select, tx_unmute, speaker_route, earpiece_route,
    input wire logic tx_serial_oe, latch_output_oe,
    input wire logic [3:0] sidetone_level, afb_range_db
);
    logic wr_r, mclk_r;
    logic [7:0] adr_r;
    logic [9:0] idle_r;
    // Track write data phases and how long the bit clock has stood still.
    always_ff @(posedge sys_clk) begin
        wr_r <= hsel && hready && htrans[1] && hwrite && !rst;
        adr_r <= haddr[7:0];
        mclk_r <= mclk;
        idle_r <= (mclk != mclk_r || rst) ? 10'h0 : idle_r + 10'(idle_r != 10'h3ff);
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    wire pw = wr_r && adr_r == PATH_OFS;
    power_up_a: assert property (wr_r && adr_r <= DAS_OFS && adr_r != RXBYTE_OFS && !hwdata[8]
        |=> powered_up)
        else $error("power up missed");
    one_byte_a: assert property (wr_r && adr_r == POWER_OFS && hwdata[1] |=> $stable(powered_up))
        else $error("bad power byte obeyed");
    mic_pick_a: assert property (pw |=> mic_select == $past(hwdata[7]))
        else $error("mic select wrong");
    route_pick_a: assert property (pw |=> {speaker_route, earpiece_route} == $past(hwdata[1:0]))
        else $error("routing wrong");
    mute_side_a: assert property (!tx_unmute |=> sidetone_level == 4'h0)
        else $error("sidetone while muted");
    afb_depth_a: assert property (wr_r && adr_r == DAS_OFS |=>
        afb_range_db == ($past(hwdata[5]) ? AFB_RANGE_DB : 4'h0))
        else $error("feedback depth wrong");
    arm_wait_a: assert property ($rose(powered_up) |-> !tx_serial_oe [*8])
        else $error("output drove too soon");
    clk_loss_a: assert property (idle_r > 10'd420 |-> !powered_up && !tx_serial_oe && !latch_output_oe)
        else $error("clock loss ignored");
endmodule
`default_nettype wire

// ==== verification/vcc_pcm_far.sv ====
// Far-end PCM bus model: bit clock, frame sync and receive data.
`timescale 1ns/10ps
`default_nettype none
module vcc_pcm_far (
    input wire logic run,
    input wire logic [7:0] rx_byte,
    output logic mclk, fsync, rx_serial
);
    int pos = 0;
    // A 5 MHz bit clock; 32 bit slots make a short frame to keep runs brief.
    initial begin
        {mclk, fsync, rx_serial} = 3'h0;
        forever begin
            #100;
            mclk = run ? ~mclk : mclk;
            if (run && mclk) begin
                fsync = (pos == 0);
                rx_serial = pos < 8 ? rx_byte[7 - pos] : ~rx_serial;
                pos = (pos + 1) % 32;
            end
        end
    end
endmodule
`default_nettype wire

// ==== verification/voice_codec_control_test.sv ====
// Self-checking bench for the voice codec control block.
`timescale 1ns/10ps
`default_nettype none
module voice_codec_control_test;
    import vcc_pkg::*;
    logic sys_clk = 0, rst = 1, hsel = 1, hwrite = 0, alt_tone_pin = 0, alt_tone_open = 1;
    logic [2:0] hsize = 3'h2;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, exp_q[$];
    logic hreadyout, hresp, mclk, fsync, rx_serial, tx_serial_o, tx_serial_oe, latch_output_o;
    logic latch_output_oe, powered_up, mic_select, tx_unmute, law_mu, speaker_route, ring_auto;
    logic earpiece_route, tone_to_earpiece, tone_to_speaker, handsfree_loop_en, ls_gain_high;
    logic [3:0] tx_stage2_gain, earpiece_atten, speaker_atten, sidetone_level, tone_level;
    logic [3:0] afb_range_db, das_reduction;
    logic [7:0] ring_freq, rx_b = 0, v, g, r, d;
    logic run = 1, rd_ph = 0;
    int err_total = 0, num_checks = 0, seed = 32'h2cb2d3f8;
    wire hready = hreadyout;
    wire [6:0] path_o = {mic_select, tx_unmute, handsfree_loop_en, tone_to_earpiece,
        tone_to_speaker, speaker_route, earpiece_route};
    wire [7:0] gain_o = {tx_stage2_gain, sidetone_level};
    wire [4:0] spk_o = {ls_gain_high, afb_range_db};
    vcc_top uut (.*);
    vcc_pcm_far far (.run(run), .rx_byte(rx_b), .mclk(mclk), .fsync(fsync), .rx_serial(rx_serial));
    initial forever #12.5 sys_clk = ~sys_clk;
    task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // One single AHB-Lite transfer; the master waits on hready in both phases.
    task automatic bus(logic w, logic [7:0] a, logic [31:0] dat);
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        do @(posedge sys_clk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= dat;
        rd_ph <= !w;
        do @(posedge sys_clk); while (hready !== 1'b1);
        rd_ph <= 1'b0;
    endtask
    task automatic wr(logic [7:0] a, logic [8:0] dat);
        bus(1'b1, a, {23'h0, dat});
    endtask
    task automatic rd(logic [7:0] a, logic [31:0] e);
        exp_q.push_back(e);
        bus(1'b0, a, 32'h0);
    endtask
    task automatic step();
        @(posedge sys_clk);
        #1;
    endtask
    // Read data is compared in its data phase against the oldest note.
    always @(posedge sys_clk)
        if (rd_ph && hready === 1'b1) check("hrdata", hrdata, exp_q.pop_front());
    initial begin
        #400us;
        err_total++;
        report_and_stop();
    end
    initial begin
        repeat (10) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        rd(8'h40, 32'h0);
        // Registers change while powered down; every write keeps power off.
        for (int i = 0; i < 8; i++) begin
            {v, g, r, d} = $random(seed);
            wr(PATH_OFS, {1'b1, v});
            wr(TXGAIN_OFS, {1'b1, g});
            wr(RXATT_OFS, {1'b1, r});
            wr(DAS_OFS, {1'b1, d});
            wr(FORMAT_OFS, {7'h40, v[1:0]});
            step();
            check("path", path_o, {v[7:5], v[3:0]});
            check("gain", gain_o, {g[7:4], g[3:0] & {4{v[6]}}});
            check("atten", {earpiece_atten, speaker_atten}, r);
            check("spk", spk_o, {d[4], {2{d[5]}}, 2'h0});
            check("law", law_mu, v[0]);
            check("power", powered_up, 1'b0);
            rd(TXGAIN_OFS, {23'h1, g});
        end
        wr(POWER_OFS, 9'h002);
        step();
        check("pwr", powered_up, 1'b0);
        wr(POWER_OFS, 9'h000);
        step();
        check("pwr", powered_up, 1'b1);
        check("kept", gain_o, {g[7:4], g[3:0] & {4{v[6]}}});
        rx_b <= d;
        wr(CHAN_OFS, 9'h00c);
        repeat (800) @(posedge sys_clk);
        rd(RXBYTE_OFS, {24'h0, d});
        wr(RING1_OFS, {1'b0, r});
        wr(RING2_OFS, {1'b0, g});
        // Pin tied high, tied low, then left open.
        for (int k = 0; k < 3; k++) begin
            alt_tone_open <= (k == 2);
            alt_tone_pin <= (k == 0);
            repeat (6) @(posedge sys_clk);
            check("ring", {ring_auto, ring_freq}, {k != 2, k == 1 ? g : r});
        end
        check("latch", latch_output_oe, 1'b1);
        run <= 1'b0;
        repeat (500) @(posedge sys_clk);
        check("loss", {powered_up, tx_serial_oe, latch_output_oe}, 3'h0);
        report_and_stop();
    end
endmodule
bind vcc_top vcc_properties chk (.*);
`default_nettype wire
